/* common/touch_scan_pkg.sv */
/*
 Constants and carrier types for the touch-key scan control block.
 Assumes a 25 MHz system clock and an 8-bit special-function register port.
*/
package touch_scan_pkg;

    localparam logic [7:0] FIRST_CHANNEL_SELECT_ADDR = 8'ha7;
    localparam logic [7:0] SENSE_CONTROL_ADDR        = 8'had;
    localparam logic [7:0] FIRST_CHANNEL_SELECT_RST  = 8'h1f;
    localparam logic [7:0] SENSE_CONTROL_RST         = 8'hd0;

    localparam int POWER_DOWN_BIT   = 7;
    localparam int DONE_BIT         = 6;
    localparam int LENGTH_AUTO_BIT  = 5;
    localparam int THRESHOLD_BIT    = 4;
    localparam int SPREAD_BIT       = 3;
    localparam int GROUP_BIT        = 2;
    localparam int MODE_MSB         = 1;
    localparam int CHANNEL_MSB      = 4;

    localparam logic [4:0] REF_CAP_CODE  = 5'h17;
    localparam int         NUM_CHANNELS  = 24;

    localparam int CLOCK_HZ            = 25000000;
    localparam int DONE_SETTLE_NS      = 3000;
    localparam int DONE_SETTLE_CYCLES  = (DONE_SETTLE_NS * (CLOCK_HZ / 1000000)) / 1000;
    localparam logic [7:0] SETTLE_LAST = 8'(DONE_SETTLE_CYCLES - 2);
    localparam logic [7:0] MEASURE_LEN = 8'h08;

    typedef enum logic [1:0] {REPEAT_1, REPEAT_2, REPEAT_4, REPEAT_8} repeat_mode_t;

    typedef struct packed {
        logic        write;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } sfr_req_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  channel;
        logic [2:0]  pass;
        logic        refCap;
        logic        spread;
        logic        bundle;
        logic        lengthAuto;
        logic [11:0] scanLength;
    } measure_t;

    typedef struct packed {
        logic [4:0]  channel;
        logic [2:0]  pass;
        logic [15:0] count;
    } result_t;

endpackage

/* design/channel_sequence_rom.sv */
/*
 Small registered memory holding the port-pin number tied to each touch channel.
 Assumes synchronous reads; the value appears one clock after the address.
*/
`timescale 1ns/1ps
module channel_sequence_rom
    import touch_scan_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       clockEnable,
    // Read port
    input  wire logic [4:0] addr,
    output logic      [5:0] pinCode
);

    function automatic logic [5:0] pinOf(input logic [4:0] ch);
        logic [5:0] table_v [0:23];
        // Each entry is {port, bit} packed as three bits each
        table_v = '{6'h1b, 6'h1a, 6'h19, 6'h18, 6'h08, 6'h09, 6'h0a, 6'h0b,
                    6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h1e, 6'h1d, 6'h1c, 6'h1f,
                    6'h10, 6'h11, 6'h03, 6'h07, 6'h06, 6'h05, 6'h04, 6'h3f};
        pinOf = (ch < 5'd24) ? table_v[ch] : 6'h3f;
    endfunction

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            pinCode <= 6'h3f;
        else if (clockEnable)
            pinCode <= pinOf(addr);
    end

endmodule

/* design/touch_key_scan_control.sv */
/*
 Control and channel sequencing of the touch-key scanner behind two SFRs.
 Assumes the analogue counter reports each measurement by countDone with its count,
 and that the result RAM accepts a write on resultValid without stalling.
*/
`timescale 1ns/1ps
module touch_key_scan_control
    import touch_scan_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clockEnable,
    // Special-function register port
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic [7:0]  sfrWdata,
    output logic      [7:0]  sfrRdata,
    // Controls held elsewhere in the chip
    input  wire logic        conversionStart,
    input  wire logic [23:0] channelEnableMask,
    input  wire logic [11:0] scanLengthSetting,
    input  wire logic        lowPowerMode,
    // Analogue measurement side
    input  wire logic        countDone,
    input  wire logic [15:0] countValue,
    output measure_t         measure,
    output logic             sensePowered,
    output logic      [5:0]  activePin,
    output logic      [1:0]  thresholdSelect,
    // Result storage side
    output logic             resultValid,
    output result_t          result
);

    typedef enum logic [2:0] {IDLE, SETTLE, PICK, RUN, STORE, FINISH} state_t;

    state_t       state_r;
    logic [4:0]   firstChannel_r;
    logic [7:0]   control_r;
    logic         autoOff_r;
    logic         startSeen_r;
    logic [7:0]   settleCnt_r;
    logic [23:0]  pending_r;
    logic [4:0]   channel_r;
    logic [2:0]   pass_r;
    logic [4:0]   doneCount_r;
    logic         powerDown;
    logic         startRise;
    repeat_mode_t mode;

    function automatic logic [2:0] lastPass(input repeat_mode_t m);
        unique case (m)
            REPEAT_1: lastPass = 3'd0;
            REPEAT_2: lastPass = 3'd1;
            REPEAT_4: lastPass = 3'd3;
            REPEAT_8: lastPass = 3'd7;
        endcase
    endfunction

    function automatic logic [4:0] maxChannels(input repeat_mode_t m);
        unique case (m)
            REPEAT_1, REPEAT_2: maxChannels = 5'd24;
            REPEAT_4:           maxChannels = 5'd16;
            REPEAT_8:           maxChannels = 5'd8;
        endcase
    endfunction

    // Lowest set bit at or above the given start position
    function automatic logic [4:0] nextChannel(input logic [23:0] m, input logic [4:0] from);
        logic [4:0] pick;
        pick = 5'h1f;
        for (int i = NUM_CHANNELS - 1; i >= 0; i--)
            if (m[i] && (5'(i) >= from))
                pick = 5'(i);
        nextChannel = pick;
    endfunction

    assign mode            = repeat_mode_t'(control_r[MODE_MSB:0]);
    assign powerDown       = control_r[POWER_DOWN_BIT] | autoOff_r;
    assign startRise       = conversionStart & ~startSeen_r;
    assign sensePowered    = ~powerDown;
    assign thresholdSelect = {control_r[THRESHOLD_BIT], ~control_r[THRESHOLD_BIT]};

    // Register writes; done flag is read-only and owned by the sequencer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstChannel_r <= FIRST_CHANNEL_SELECT_RST[CHANNEL_MSB:0];
            control_r      <= SENSE_CONTROL_RST;
        end
        else if (clockEnable)
        begin
            if (sfrWrite && sfrAddr == FIRST_CHANNEL_SELECT_ADDR)
                firstChannel_r <= sfrWdata[CHANNEL_MSB:0];
            if (sfrWrite && sfrAddr == SENSE_CONTROL_ADDR)
            begin
                control_r[POWER_DOWN_BIT]     <= sfrWdata[POWER_DOWN_BIT];
                control_r[LENGTH_AUTO_BIT:0]  <= sfrWdata[LENGTH_AUTO_BIT:0];
            end
            if (startRise && !powerDown && state_r == IDLE)
                control_r[DONE_BIT] <= 1'b0;
            else if (state_r == FINISH)
                control_r[DONE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            sfrRdata <= 8'h00;
        else if (clockEnable && sfrRead)
            unique case (sfrAddr)
                FIRST_CHANNEL_SELECT_ADDR: sfrRdata <= {3'b000, firstChannel_r};
                SENSE_CONTROL_ADDR:        sfrRdata <= control_r;
                default:                   sfrRdata <= 8'h00;
            endcase
    end

    // Automatic shutdown in idle, halt and stop once no conversion runs
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            autoOff_r <= 1'b0;
        else if (clockEnable)
            autoOff_r <= lowPowerMode && (state_r == IDLE);
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            startSeen_r <= 1'b0;
        else if (clockEnable)
            startSeen_r <= conversionStart;
    end

    // Sequencer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r     <= IDLE;
            settleCnt_r <= 8'h00;
            pending_r   <= '0;
            channel_r   <= 5'h00;
            pass_r      <= 3'd0;
            doneCount_r <= 5'd0;
        end
        else if (clockEnable)
        begin
            unique case (state_r)
                IDLE:
                    if (startRise && !powerDown)
                    begin
                        state_r     <= SETTLE;
                        settleCnt_r <= 8'h00;
                        pending_r   <= channelEnableMask;
                        doneCount_r <= 5'd0;
                    end
                SETTLE:
                    if (settleCnt_r == SETTLE_LAST)
                        state_r <= PICK;
                    else
                        settleCnt_r <= settleCnt_r + 8'h01;
                PICK:
                begin
                    pass_r <= 3'd0;
                    if (pending_r == '0)
                    begin
                        if (doneCount_r == 5'd0)
                        begin
                            channel_r <= firstChannel_r;
                            state_r   <= RUN;
                        end
                        else
                            state_r <= FINISH;
                    end
                    else if (doneCount_r >= maxChannels(mode) && mode != REPEAT_1 && mode != REPEAT_2)
                        state_r <= FINISH;
                    else
                    begin
                        channel_r <= nextChannel(pending_r, 5'h00);
                        state_r   <= RUN;
                    end
                end
                RUN:
                    if (countDone)
                        state_r <= STORE;
                STORE:
                begin
                    if (pass_r == lastPass(mode))
                    begin
                        pending_r[channel_r] <= 1'b0;
                        doneCount_r          <= doneCount_r + 5'd1;
                        state_r              <= (pending_r == '0) ? FINISH : PICK;
                    end
                    else
                    begin
                        pass_r  <= pass_r + 3'd1;
                        state_r <= RUN;
                    end
                end
                FINISH:
                    state_r <= IDLE;
                default:
                    state_r <= IDLE;
            endcase
        end
    end

    channel_sequence_rom pinMap (
        .clock       (clock),
        .arst_n      (arst_n),
        .clockEnable (clockEnable),
        .addr        (channel_r),
        .pinCode     (activePin)
    );

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            measure <= '0;
        else if (clockEnable)
        begin
            measure.valid      <= (state_r == RUN);
            measure.channel    <= channel_r;
            measure.pass       <= pass_r;
            measure.refCap     <= (channel_r == REF_CAP_CODE);
            measure.spread     <= control_r[SPREAD_BIT];
            measure.bundle     <= control_r[GROUP_BIT];
            measure.lengthAuto <= control_r[LENGTH_AUTO_BIT];
            measure.scanLength <= control_r[LENGTH_AUTO_BIT] ? 12'hfff : scanLengthSetting;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resultValid <= 1'b0;
            result      <= '0;
        end
        else if (clockEnable)
        begin
            resultValid <= (state_r == RUN) && countDone;
            if (state_r == RUN && countDone)
                result <= '{channel: channel_r, pass: pass_r, count: countValue};
        end
    end

endmodule

/* verif/touch_key_scan_control_properties.sv */
/* Port checker for the touch scan control block.
   Assumes the bind at the foot reaches every instance. */
`timescale 1ns/1ps
module touch_key_scan_control_properties
    import touch_scan_pkg::*;
(
    // Watched ports
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        clockEnable,
    input wire logic        sfrWrite,
    input wire logic [7:0]  sfrAddr,
    input wire logic [7:0]  sfrWdata,
    input wire logic        conversionStart,
    input wire logic [11:0] scanLengthSetting,
    input wire logic        lowPowerMode,
    input wire logic        countDone,
    input wire measure_t    measure,
    input wire logic        sensePowered,
    input wire logic [5:0]  activePin,
    input wire logic        resultValid
);
    logic [7:0] control_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Copy of the control register as software wrote it
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            control_r <= SENSE_CONTROL_RST;
        else if (clockEnable && sfrWrite && sfrAddr == SENSE_CONTROL_ADDR)
            control_r <= sfrWdata;

    refcap_flag_a: assert property (measure.valid && measure.channel < 5'h18 |-> measure.refCap == (activePin == 6'h3f))
        else $error("reference flag wrong");
    spread_follow_a: assert property (measure.valid |-> measure.spread == control_r[SPREAD_BIT])
        else $error("spread setting lost");
    group_follow_a: assert property (measure.valid |-> measure.bundle == control_r[GROUP_BIT])
        else $error("group setting lost");
    manual_length_a: assert property (measure.valid && !control_r[LENGTH_AUTO_BIT] |->
        measure.scanLength == scanLengthSetting) else $error("manual length lost");
    power_gate_a: assert property (control_r[POWER_DOWN_BIT] |-> !sensePowered)
        else $error("powered while off");
    result_follow_a: assert property (countDone && measure.valid |=> resultValid)
        else $error("result not stored");
    pass_bound_a: assert property (measure.valid |-> measure.pass < (4'h1 << control_r[1:0]))
        else $error("too many passes");
    start_delay_a: assert property ($rose(conversionStart) && !control_r[POWER_DOWN_BIT] &&
        !lowPowerMode && !measure.valid |-> ##77 measure.valid) else $error("late measurement");
    start_refused_a: assert property ($rose(conversionStart) && control_r[POWER_DOWN_BIT] |->
        !measure.valid [*8]) else $error("started while off");
endmodule

bind touch_key_scan_control touch_key_scan_control_properties checker_i (.clock, .arst_n, .clockEnable,
    .sfrWrite, .sfrAddr, .sfrWdata, .conversionStart, .scanLengthSetting, .lowPowerMode, .countDone,
    .measure, .sensePowered, .activePin, .resultValid);

/* verif/touch_electrode_model.sv */
/* Electrode model: one count pulse per measurement after a set delay.
   Assumes a measurement is known by its channel and pass. */
`timescale 1ns/1ps
module touch_electrode_model
    import touch_scan_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Measurement side
    input  wire measure_t    measure,
    input  wire logic [4:0]  delay,
    output logic             countDone,
    output logic      [15:0] countValue
);
    logic [4:0] waitCount_r;
    logic [7:0] lastKey_r;

    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
        begin
            waitCount_r <= 5'h0;
            lastKey_r   <= 8'hff;
            countDone   <= 1'h0;
            countValue  <= 16'h0;
        end
        else
        begin
            countDone  <= 1'h0;
            countValue <= ~countValue;
            if (!measure.valid)
                lastKey_r <= 8'hff;
            else if ({measure.channel, measure.pass} != lastKey_r)
            begin
                waitCount_r <= waitCount_r + 5'h1;
                if (waitCount_r == delay)
                begin
                    countDone   <= 1'h1;
                    countValue  <= {measure.channel, measure.pass, 8'h5a};
                    lastKey_r   <= {measure.channel, measure.pass};
                    waitCount_r <= 5'h0;
                end
            end
        end
endmodule

/* verif/touch_key_scan_control_tb.sv */
/* Self-checking bench of the touch scan control block.
   Assumes the electrode model answers every measurement. */
`timescale 1ns/1ps
module touch_key_scan_control_tb
    import touch_scan_pkg::*;
;
    logic        clock = 1'h0;
    logic        arst_n = 1'h0;
    logic        sfrWrite = 1'h0;
    logic        sfrRead = 1'h0;
    logic [7:0]  sfrAddr = 8'h0;
    logic [7:0]  sfrWdata = 8'h0;
    logic        conversionStart = 1'h0;
    logic        lowPowerMode = 1'h0;
    logic [23:0] mask = 24'h0;
    logic [11:0] lenSet = 12'h0;
    logic [4:0]  delay = 5'h0;
    logic [7:0]  readData, curCtl, e;
    logic [7:0]  sfrRdata;
    logic [5:0]  activePin;
    logic [1:0]  thresholdSelect;
    logic        countDone, sensePowered, resultValid;
    logic [15:0] countValue;
    measure_t    measure;
    result_t     result;
    logic [7:0]  expQ[$];
    int          failures = 0, checked = 0, cycles = 0, seed = 32'hc298a469;

    touch_key_scan_control dut (.clock, .arst_n, .clockEnable(1'h1), .sfrWrite, .sfrRead, .sfrAddr, .sfrWdata,
        .sfrRdata, .conversionStart, .channelEnableMask(mask), .scanLengthSetting(lenSet), .lowPowerMode,
        .countDone, .countValue, .measure, .sensePowered, .activePin, .thresholdSelect, .resultValid, .result);
    touch_electrode_model pads (.clock, .arst_n, .measure, .delay, .countDone, .countValue);

    always #20 clock = ~clock;

    task automatic end_sim;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrWrite <= 1'h1;
        sfrAddr  <= a;
        sfrWdata <= d;
        @(posedge clock);
        sfrWrite <= 1'h0;
    endtask

    task automatic sfr_read(input logic [7:0] a);
        @(posedge clock);
        sfrRead <= 1'h1;
        sfrAddr <= a;
        @(posedge clock);
        sfrRead <= 1'h0;
        #1 readData = sfrRdata;
    endtask

    function automatic logic [5:0] pin(input logic [4:0] c);
        string s = "3332313010111213141516173635343720210307060504";
        if (c > 5'h16)
            return 6'h3f;
        return {3'(s[2 * c] - "0"), 3'(s[2 * c + 1] - "0")};
    endfunction

    // Expected measurement order: lowest channel first, passes per mode, channel cap per mode
    function automatic void plan(input logic [23:0] m, input logic [1:0] md);
        int lim = (md == 2'h3) ? 8 : (md == 2'h2) ? 16 : 24;
        int n = 0;
        // Empty mask scans the first channel, left at the reference code by the sweep
        if (m == 24'h0)
            for (int p = 0; p < (1 << md); p++)
                expQ.push_back({REF_CAP_CODE, 3'(p)});
        for (int c = 0; c < 24; c++)
            if (m[c] && n < lim)
            begin
                n++;
                for (int p = 0; p < (1 << md); p++)
                    expQ.push_back({5'(c), 3'(p)});
            end
    endfunction

    task automatic scan(input logic [7:0] ctl);
        curCtl = ctl;
        sfr_write(SENSE_CONTROL_ADDR, ctl);
        plan(mask, ctl[1:0]);
        conversionStart <= 1'h1;
        repeat (75) @(posedge clock);
        check(24'(thresholdSelect), ctl[THRESHOLD_BIT] ? 24'h2 : 24'h1);
        conversionStart <= 1'h0;
        sfr_read(SENSE_CONTROL_ADDR);
        check(24'(readData[DONE_BIT]), 24'h0);
        for (int n = 0; n < 3000 && readData[DONE_BIT] !== 1'h1; n++)
            sfr_read(SENSE_CONTROL_ADDR);
        check(24'(readData[DONE_BIT]), 24'h1);
        check(24'(expQ.size()), 24'h0);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            failures++;
            end_sim;
        end
        if (countDone && measure.valid)
            check({activePin, measure.spread, measure.bundle, measure.lengthAuto, measure.scanLength},
                {pin(measure.channel), curCtl[SPREAD_BIT], curCtl[GROUP_BIT], curCtl[LENGTH_AUTO_BIT],
                curCtl[LENGTH_AUTO_BIT] ? 12'hfff : lenSet});
        if (resultValid)
        begin
            e = (expQ.size() != 0) ? expQ.pop_front() : 8'hff;
            check({result.channel, result.pass, result.count}, {e, e, 8'h5a});
        end
    end

    initial
    begin
        logic [23:0] m;
        repeat (20) @(posedge clock);
        arst_n <= 1'h1;
        sfr_read(FIRST_CHANNEL_SELECT_ADDR);
        check(24'(readData), 24'(FIRST_CHANNEL_SELECT_RST));
        sfr_read(SENSE_CONTROL_ADDR);
        check(24'(readData), 24'(SENSE_CONTROL_RST));
        sfr_read(8'h00);
        check(24'(readData), 24'h0);
        for (int c = 0; c < 24; c++)
        begin
            sfr_write(FIRST_CHANNEL_SELECT_ADDR, 8'(c));
            sfr_read(FIRST_CHANNEL_SELECT_ADDR);
            check(24'(readData), 24'(c));
        end
        sfr_write(SENSE_CONTROL_ADDR, 8'h80);
        sfr_read(SENSE_CONTROL_ADDR);
        check(24'(readData), 24'hc0);
        conversionStart <= 1'h1;
        repeat (80) @(posedge clock);
        conversionStart <= 1'h0;
        sfr_read(SENSE_CONTROL_ADDR);
        check(24'(readData[DONE_BIT]), 24'h1);
        for (int i = 0; i < 12; i++)
        begin
            m = (i == 0) ? 24'h800000 : (i < 4) ? 24'hffffff : (i == 4) ? 24'h0 : 24'($random(seed)) | 24'h1;
            mask   <= m;
            delay  <= (i == 0) ? 5'h0 : 5'($random(seed));
            lenSet <= 12'($random(seed));
            scan({2'h0, 4'($random(seed)), 2'(i)});
        end
        check(24'(sensePowered), 24'h1);
        lowPowerMode <= 1'h1;
        repeat (3) @(posedge clock);
        check(24'(sensePowered), 24'h0);
        end_sim;
    end
endmodule
